// ---- rtl/sync_fifo_ctl_pkg.sv ----
// Shared constants, enumerations and pin carriers for the port-A to port-B FIFO controller.
// Assumes one core clock; every port pin arrives asynchronously and is synchronised by the user module.
package sync_fifo_ctl_pkg;

  // Data path and offset widths
  localparam int              WORD_W       = 36;
  localparam int              OFS_W        = 11;

  // Preset offset values for the almost-empty and almost-full registers
  localparam logic [10:0]     PRESET_LO    = 11'h008;
  localparam logic [10:0]     PRESET_HI    = 11'h040;

  // Offset programming counts
  localparam logic [4:0]      SERIAL_BITS  = 5'h16;
  localparam logic [1:0]      INIT_EDGES   = 2'h2;
  localparam logic [1:0]      PAR_LOADS    = 2'h2;

  // Software register offsets (byte addresses)
  localparam logic [3:0]      REG_CTRL     = 4'h0;
  localparam logic [3:0]      REG_STATUS   = 4'h4;
  localparam logic [3:0]      REG_OFFSETS  = 4'h8;

  // Control register layout and reset value
  localparam int              CTRL_CLEAR_BIT = 0;
  localparam logic            CTRL_RESET   = 1'h0;

  // Offset programming method latched at the end of a device clear
  typedef enum logic [1:0] {
    OFS_PARALLEL  = 2'b00,
    OFS_PRESET_LO = 2'b01,
    OFS_PRESET_HI = 2'b10,
    OFS_SERIAL    = 2'b11
  } ofs_mode_type;

  // Initialisation sequence states
  typedef enum logic [2:0] {
    ST_CLEAR  = 3'b000,
    ST_SETTLE = 3'b001,
    ST_SHIFT  = 3'b010,
    ST_ARM    = 3'b011,
    ST_RUN    = 3'b100
  } init_state_type;

  // Pins of one data port
  typedef struct packed {
    logic              clock;
    logic              select_n;
    logic              dir;
    logic              gate;
    logic              pick;
    logic [WORD_W-1:0] data;
  } port_pins_type;

  // Device-wide control pins
  typedef struct packed {
    logic clear_n;
    logic retx_restart;
    logic retx_mode_sel;
    logic sel_hi;
    logic sel_lo;
  } misc_pins_type;

endpackage : sync_fifo_ctl_pkg

// ---- rtl/sync_fifo_ctl.sv ----
// Port-A to port-B FIFO with mailboxes, retransmit and offset programming.
// Assumes port clocks and all pins are slow, asynchronous levels sampled by i_core_clk.

// Functional notes
// - Mailbox write from B drives mail_to_a low
// - Mailbox read on A releases mail_to_a high
// - Reset forces both mailbox flags high
// - out_ready low blocks reads; high means data
// - out_ready low in reset, rises third edge
// - Restart reloads read pointer from mark
// - Mode select with data marks start word
// - Mark holds until mode select sampled low
// - port_a_dir high writes; A outputs off then
// - port_b_dir low writes; B outputs off then
// - Reset clears pointers and drops in_ready
// - in_ready rises second A edge after reset
// - Clear release latches offset programming method
// - Preset loads both offset registers
// - First two parallel writes load Y, X
// - Parallel offsets come from data bits 10:0
// - Serial bits shift in, 22 total, Y first
// - Serial mode in_ready rises after last bit
// - A mailbox read needs select, dir, gate, pick
// - B mirrors A with inverted direction
// - FIFO read needs select, gate, out_ready
module sync_fifo_ctl
  import sync_fifo_ctl_pkg::*;
#(
  parameter int DEPTH_LOG2 = 11
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire port_pins_type     i_port_a,
  input  wire port_pins_type     i_port_b,
  input  wire misc_pins_type     i_misc,
  input  wire logic [3:0]        i_reg_addr,
  input  wire logic [31:0]       i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic [31:0]            o_reg_rdata,
  output logic [WORD_W-1:0]      o_port_a_data,
  output logic                   o_port_a_data_oe,
  output logic [WORD_W-1:0]      o_port_b_data,
  output logic                   o_port_b_data_oe,
  output logic                   o_in_ready,
  output logic                   o_out_ready,
  output logic                   o_mail_to_b_flag_n,
  output logic                   o_mail_to_a_flag_n
);

  localparam int                 AW       = DEPTH_LOG2;
  localparam logic [AW+1:0]      FULL_CNT = (AW+2)'(1) << AW;

  port_pins_type      a_s1_q, a_s2_q;       // Port A synchroniser
  port_pins_type      b_s1_q, b_s2_q;       // Port B synchroniser
  misc_pins_type      m_s1_q, m_s2_q;       // Control pin synchroniser
  logic               a_clk_prev_q;         // Last sampled port A clock
  logic               b_clk_prev_q;         // Last sampled port B clock
  logic               clear_prev_q;         // Device clear one cycle ago
  logic               soft_clear_q;         // Software held device clear
  logic [WORD_W-1:0]  mem_q [1<<AW];        // FIFO storage
  logic [AW:0]        wr_ptr_q;             // Write pointer
  logic [AW:0]        rd_ptr_q;             // Read pointer
  logic [AW:0]        wr_seen1_q;           // Write pointer seen by B, stage 1
  logic [AW:0]        wr_seen2_q;           // Write pointer seen by B, stage 2
  logic [AW:0]        mark_q;               // Retransmit start location
  logic               retx_q;               // Retransmit mode active
  logic [WORD_W-1:0]  out_word_q;           // FIFO output register
  logic               out_ready_q;          // Output register holds new data
  logic               in_ready_q;           // Writes accepted
  logic [WORD_W-1:0]  a_to_b_q;             // Mailbox toward port B
  logic [WORD_W-1:0]  b_to_a_q;             // Mailbox toward port A
  logic               mail_to_b_q;          // Flag, low while new mail for B
  logic               mail_to_a_q;          // Flag, low while new mail for A
  init_state_type     state_q;              // Initialisation sequence
  ofs_mode_type       mode_q;               // Latched offset method
  logic [OFS_W-1:0]   ofs_x_q;              // Almost-empty offset
  logic [OFS_W-1:0]   ofs_y_q;              // Almost-full offset
  logic [4:0]         bit_cnt_q;            // Serial bits received
  logic [1:0]         edge_cnt_q;           // A edges since release
  logic [1:0]         par_cnt_q;            // Parallel offset loads done

  logic               a_edge, b_edge;       // Port clock rising edges
  logic               clear_act, rst_all;   // Device clear in force
  logic               a_sel, b_sel;         // Port enabled this edge
  logic               fifo_wr, mem_wr, par_load;
  logic               fifo_rd;
  logic               mb_a_wr, mb_a_rd, mb_b_wr, mb_b_rd;
  logic [AW:0]        fill;                 // Words held, mark counted
  logic [AW+1:0]      fill_after;           // Fill after this edge

  // Two-stage synchronisers on every pin
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      a_s1_q <= '0;
      a_s2_q <= '0;
      b_s1_q <= '0;
      b_s2_q <= '0;
      m_s1_q <= '0;                          // Clear looks asserted after power-up
      m_s2_q <= '0;
    end
    else
    begin
      a_s1_q <= i_port_a;
      a_s2_q <= a_s1_q;
      b_s1_q <= i_port_b;
      b_s2_q <= b_s1_q;
      m_s1_q <= i_misc;
      m_s2_q <= m_s1_q;
    end
  end

  // Edge history of port clocks and device clear
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      a_clk_prev_q <= 1'b0;
      b_clk_prev_q <= 1'b0;
      clear_prev_q <= 1'b1;
    end
    else
    begin
      a_clk_prev_q <= a_s2_q.clock;
      b_clk_prev_q <= b_s2_q.clock;
      clear_prev_q <= clear_act;
    end
  end

  // Edge and operation decode
  always_comb
  begin
    a_edge     = a_s2_q.clock & ~a_clk_prev_q;
    b_edge     = b_s2_q.clock & ~b_clk_prev_q;
    clear_act  = ~m_s2_q.clear_n | soft_clear_q;
    rst_all    = i_sys_rst | clear_act;
    a_sel      = a_edge & ~a_s2_q.select_n & a_s2_q.gate;
    b_sel      = b_edge & ~b_s2_q.select_n & b_s2_q.gate;
    fifo_wr    = a_sel & a_s2_q.dir & ~a_s2_q.pick & in_ready_q;
    mb_a_wr    = a_sel & a_s2_q.dir & a_s2_q.pick;
    mb_a_rd    = a_sel & ~a_s2_q.dir & a_s2_q.pick;
    mb_b_wr    = b_sel & ~b_s2_q.dir & b_s2_q.pick;
    mb_b_rd    = b_sel & b_s2_q.dir & b_s2_q.pick;
    fifo_rd    = b_sel & b_s2_q.dir & ~b_s2_q.pick & out_ready_q;
    par_load   = fifo_wr & (mode_q == OFS_PARALLEL) & (par_cnt_q < PAR_LOADS);
    mem_wr     = fifo_wr & ~par_load;
    fill       = wr_ptr_q - (retx_q ? mark_q : rd_ptr_q);
    fill_after = {1'b0, fill} + {{(AW+1){1'b0}}, mem_wr};
  end

  // FIFO storage write
  always_ff @(posedge i_core_clk)
  begin
    if (mem_wr)
    begin
      mem_q[wr_ptr_q[AW-1:0]] <= a_s2_q.data;
    end
  end

  // Write pointer
  always_ff @(posedge i_core_clk)
  begin
    if (rst_all)
    begin
      wr_ptr_q <= '0;
    end
    else if (mem_wr)
    begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
    end
  end

  // Retransmit mode and mark
  always_ff @(posedge i_core_clk)
  begin
    if (rst_all)
    begin
      retx_q <= 1'b0;
      mark_q <= '0;
    end
    else if (b_edge)
    begin
      if (!m_s2_q.retx_mode_sel)
      begin
        retx_q <= 1'b0;
      end
      else if (out_ready_q && !retx_q)
      begin
        retx_q <= 1'b1;
        mark_q <= rd_ptr_q - (AW+1)'(1);
      end
    end
  end

  // Read side: pointer view, output register and out_ready
  always_ff @(posedge i_core_clk)
  begin
    if (rst_all)
    begin
      rd_ptr_q    <= '0;
      wr_seen1_q  <= '0;
      wr_seen2_q  <= '0;
      out_word_q  <= '0;
      out_ready_q <= 1'b0;
    end
    else if (b_edge)
    begin
      wr_seen1_q <= wr_ptr_q;
      wr_seen2_q <= wr_seen1_q;
      if (retx_q && m_s2_q.retx_restart)
      begin
        out_word_q  <= mem_q[mark_q[AW-1:0]];
        rd_ptr_q    <= mark_q + (AW+1)'(1);
        out_ready_q <= 1'b1;
      end
      else if (!out_ready_q || fifo_rd)
      begin
        if (wr_seen2_q != rd_ptr_q)
        begin
          out_word_q  <= mem_q[rd_ptr_q[AW-1:0]];
          rd_ptr_q    <= rd_ptr_q + (AW+1)'(1);
          out_ready_q <= 1'b1;
        end
        else
        begin
          out_ready_q <= 1'b0;
        end
      end
    end
  end

  // Initialisation, offset programming and in_ready
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      state_q    <= ST_CLEAR;
      mode_q     <= OFS_PARALLEL;
      ofs_x_q    <= '0;
      ofs_y_q    <= '0;
      in_ready_q <= 1'b0;
      bit_cnt_q  <= '0;
      edge_cnt_q <= '0;
      par_cnt_q  <= '0;
    end
    else if (clear_act)
    begin
      state_q    <= ST_CLEAR;
      in_ready_q <= 1'b0;
      bit_cnt_q  <= '0;
      edge_cnt_q <= '0;
      par_cnt_q  <= '0;
    end
    else
    begin
      case (state_q)
        ST_CLEAR:
        begin
          mode_q <= ofs_mode_type'({m_s2_q.sel_hi, m_s2_q.sel_lo});
          if (m_s2_q.sel_hi && !m_s2_q.sel_lo)
          begin
            ofs_x_q <= PRESET_HI;
            ofs_y_q <= PRESET_HI;
          end
          else if (!m_s2_q.sel_hi && m_s2_q.sel_lo)
          begin
            ofs_x_q <= PRESET_LO;
            ofs_y_q <= PRESET_LO;
          end
          state_q <= (m_s2_q.sel_hi && m_s2_q.sel_lo) ? ST_SHIFT : ST_SETTLE;
        end
        ST_SETTLE:
        begin
          if (a_edge)
          begin
            edge_cnt_q <= edge_cnt_q + 2'h1;
            if (edge_cnt_q == INIT_EDGES - 2'h1)
            begin
              state_q    <= ST_RUN;
              in_ready_q <= 1'b1;
            end
          end
        end
        ST_SHIFT:
        begin
          if (a_edge && !m_s2_q.sel_hi)
          begin
            {ofs_y_q, ofs_x_q} <= {ofs_y_q[OFS_W-2:0], ofs_x_q, m_s2_q.sel_lo};
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == SERIAL_BITS - 5'h01)
            begin
              state_q <= ST_ARM;
            end
          end
        end
        ST_ARM:
        begin
          if (a_edge)
          begin
            state_q    <= ST_RUN;
            in_ready_q <= 1'b1;
          end
        end
        ST_RUN:
        begin
          if (a_edge)
          begin
            in_ready_q <= (fill_after < FULL_CNT);
          end
          if (par_load)
          begin
            par_cnt_q <= par_cnt_q + 2'h1;
            if (par_cnt_q == 2'h0)
            begin
              ofs_y_q <= a_s2_q.data[OFS_W-1:0];
            end
            else
            begin
              ofs_x_q <= a_s2_q.data[OFS_W-1:0];
            end
          end
        end
        default:
        begin
          state_q <= ST_CLEAR;
        end
      endcase
    end
  end

  // Mailbox registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      a_to_b_q <= '0;
      b_to_a_q <= '0;
    end
    else
    begin
      if (mb_a_wr)
      begin
        a_to_b_q <= a_s2_q.data;
      end
      if (mb_b_wr)
      begin
        b_to_a_q <= b_s2_q.data;
      end
    end
  end

  // Mailbox flags; a new write wins over a same-cycle read
  always_ff @(posedge i_core_clk)
  begin
    if (rst_all)
    begin
      mail_to_b_q <= 1'b1;
      mail_to_a_q <= 1'b1;
    end
    else
    begin
      if (mb_b_rd)
      begin
        mail_to_b_q <= 1'b1;
      end
      if (mb_a_wr)
      begin
        mail_to_b_q <= 1'b0;
      end
      if (mb_a_rd)
      begin
        mail_to_a_q <= 1'b1;
      end
      if (mb_b_wr)
      begin
        mail_to_a_q <= 1'b0;
      end
    end
  end

  // Port data outputs and enables
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_port_a_data    <= '0;
      o_port_a_data_oe <= 1'b0;
      o_port_b_data    <= '0;
      o_port_b_data_oe <= 1'b0;
    end
    else
    begin
      o_port_a_data    <= b_to_a_q;
      o_port_a_data_oe <= ~a_s2_q.select_n & ~a_s2_q.dir;
      o_port_b_data    <= b_s2_q.pick ? a_to_b_q : out_word_q;
      o_port_b_data_oe <= ~b_s2_q.select_n & b_s2_q.dir;
    end
  end

  // Software register port
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      soft_clear_q <= CTRL_RESET;
      o_reg_rdata  <= '0;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == REG_CTRL)
      begin
        soft_clear_q <= i_reg_wdata[CTRL_CLEAR_BIT];
      end
      if (!i_reg_rd)
      begin
        o_reg_rdata <= '0;
      end
      else if (i_reg_addr == REG_CTRL)
      begin
        o_reg_rdata <= {31'h0, soft_clear_q};
      end
      else if (i_reg_addr == REG_STATUS)
      begin
        o_reg_rdata <= {24'h0, state_q == ST_RUN, mode_q, retx_q,
                        mail_to_a_q, mail_to_b_q, out_ready_q, in_ready_q};
      end
      else if (i_reg_addr == REG_OFFSETS)
      begin
        o_reg_rdata <= {5'h0, ofs_y_q, 5'h0, ofs_x_q};
      end
      else
      begin
        o_reg_rdata <= '0;
      end
    end
  end

  assign o_in_ready         = in_ready_q;
  assign o_out_ready        = out_ready_q;
  assign o_mail_to_b_flag_n = mail_to_b_q;
  assign o_mail_to_a_flag_n = mail_to_a_q;

  // Checks
  default clocking chk_cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  sequence seq_release;
    clear_prev_q && !clear_act;
  endsequence

  sequence seq_preset_sel;
    m_s2_q.sel_hi != m_s2_q.sel_lo;
  endsequence

  a_mail_set_a: assert property (mb_b_wr |=> !o_mail_to_a_flag_n)
    else $error("mail_to_a flag not set by B mailbox write");
  a_mail_clr_a: assert property (mb_a_rd && !mb_b_wr && !rst_all |=> o_mail_to_a_flag_n)
    else $error("mail_to_a flag not released by A read");
  a_reset_state: assert property (clear_act |=> o_mail_to_a_flag_n && o_mail_to_b_flag_n
                                   && !o_out_ready && !o_in_ready && wr_ptr_q == '0)
    else $error("device clear left flags or pointers set");
  a_empty_hold: assert property (!out_ready_q && !b_edge |=> !out_ready_q && $stable(out_word_q))
    else $error("output register moved while empty");
  a_oe_port_a: assert property (a_s2_q.dir |=> !o_port_a_data_oe)
    else $error("port A driven during write select");
  a_oe_port_b: assert property (!b_s2_q.dir |=> !o_port_b_data_oe)
    else $error("port B driven during write select");
  a_mark_hold: assert property (retx_q && !clear_act && !(b_edge && !m_s2_q.retx_mode_sel)
                                |=> retx_q && $stable(mark_q))
    else $error("retransmit mark changed in retransmit mode");
  a_serial_low: assert property (state_q == ST_SHIFT || state_q == ST_ARM |-> !in_ready_q)
    else $error("in_ready high before serial offsets complete");
  a_preset_load: assert property (seq_release ##0 seq_preset_sel |=> ofs_x_q == ofs_y_q
                                  && (ofs_x_q == PRESET_LO || ofs_x_q == PRESET_HI))
    else $error("preset not loaded into both offsets");

endmodule : sync_fifo_ctl

// ---- sim/port_host.sv ----
// Host model for one FIFO port: one clocked transfer at a time on the port pins.
// Assumes the controller samples every pin on i_core_clk through its own synchroniser.
module port_host
  import sync_fifo_ctl_pkg::*;
(
  input  wire logic    i_core_clk,
  output port_pins_type o_pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle port: deselected, clock low
  initial
  begin
    o_pins          = '0;
    o_pins.select_n = 1'b1;
  end

  // Pins settle with clock low, one rising edge, then the port is released
  task automatic op(input logic sn, input logic dir, input logic gate, input logic pick,
                    input logic [WORD_W-1:0] d);
    @(posedge i_core_clk);
    o_pins.select_n <= sn;
    o_pins.dir      <= dir;
    o_pins.gate     <= gate;
    o_pins.pick     <= pick;
    o_pins.data     <= d;
    repeat (2) @(posedge i_core_clk);
    o_pins.clock <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    o_pins.clock <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    // Released bus shows no stale value
    o_pins.select_n <= 1'b1;
    o_pins.gate     <= 1'b0;
    o_pins.data     <= ~d;
    @(negedge i_core_clk);
  endtask : op
endmodule : port_host

// ---- sim/sync_fifo_ctl_tb.sv ----
// Self-checking bench for the port-A to port-B FIFO controller.
// Assumes two port_host models on the ports and the register port driven here.
module sync_fifo_ctl_tb
  import sync_fifo_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [35:0] W1 = 36'h123456789; // FIFO words
  localparam logic [35:0] W2 = 36'hA5A5A5A5A;
  localparam logic [35:0] W3 = 36'h987654321;
  localparam logic [35:0] MA = 36'h0F0F0F0F0; // Mailbox words
  localparam logic [35:0] MB = 36'hC3C3C3C3C;
  // Serial offsets, Y then X, both near the ends of the 11-bit range
  localparam logic [21:0] SER = {11'h7FC, 11'h001};

  logic          core_clk = 1'b0;          // Core clock
  logic          sys_rst  = 1'b1;          // Reset
  logic [3:0]    addr     = 4'h0;          // Register bus
  logic [31:0]   wdata    = 32'h0;
  logic          wr       = 1'b0;
  logic          rd       = 1'b0;
  logic [31:0]   rdata;
  misc_pins_type misc = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1}; // Preset 8 at first clear
  port_pins_type pins_a;                   // Port pins from hosts
  port_pins_type pins_b;
  logic [35:0]   a_data, b_data;
  logic          a_oe, b_oe, in_rdy, out_rdy, mb_flag_n, ma_flag_n;
  int            n_errors  = 0;
  int            tests_run = 0;
  int            cycles    = 0;

  // Clock, 50 ns period
  always #25 core_clk = ~core_clk;

  sync_fifo_ctl #(.DEPTH_LOG2(4)) sync_fifo_ctl_inst (
    .i_core_clk         (core_clk),
    .i_sys_rst          (sys_rst),
    .i_port_a           (pins_a),
    .i_port_b           (pins_b),
    .i_misc             (misc),
    .i_reg_addr         (addr),
    .i_reg_wdata        (wdata),
    .i_reg_wr           (wr),
    .i_reg_rd           (rd),
    .o_reg_rdata        (rdata),
    .o_port_a_data      (a_data),
    .o_port_a_data_oe   (a_oe),
    .o_port_b_data      (b_data),
    .o_port_b_data_oe   (b_oe),
    .o_in_ready         (in_rdy),
    .o_out_ready        (out_rdy),
    .o_mail_to_b_flag_n (mb_flag_n),
    .o_mail_to_a_flag_n (ma_flag_n)
  );

  port_host ha (.i_core_clk(core_clk), .o_pins(pins_a));
  port_host hb (.i_core_clk(core_clk), .o_pins(pins_b));

  // Compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One-cycle register write
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : reg_wr

  // One-cycle register read, data taken in the following cycle
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : reg_rd

  // Soft clear held long, then released with the given method pins
  task automatic soft_clear(input logic hi, input logic lo);
    logic [31:0] c;
    @(posedge core_clk);
    misc.sel_hi <= hi;
    misc.sel_lo <= lo;
    reg_wr(REG_CTRL, 32'h1);
    reg_rd(REG_CTRL, c);
    check(c, 32'h1);
    repeat (4) @(posedge core_clk);
    reg_wr(REG_CTRL, 32'h0);
    repeat (6) @(posedge core_clk);
  endtask : soft_clear

  // Counts and verdict
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    logic [31:0] v;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    check(mb_flag_n, 1'b1);
    check(ma_flag_n, 1'b1);
    check(in_rdy, 1'b0);
    check(out_rdy, 1'b0);
    repeat (8) @(posedge core_clk);
    reg_rd(REG_STATUS, v);
    check(v[6:5], 2'b01);
    reg_rd(REG_OFFSETS, v);
    check(v, 32'h00080008);
    ha.op(1'b1, 1'b1, 1'b0, 1'b0, W1);
    check(in_rdy, 1'b0);
    ha.op(1'b1, 1'b1, 1'b0, 1'b0, W1);
    check(in_rdy, 1'b1);
    // Two FIFO words, then output-ready latency
    ha.op(1'b0, 1'b1, 1'b1, 1'b0, W1);
    check(a_oe, 1'b0);
    ha.op(1'b0, 1'b1, 1'b1, 1'b0, W2);
    hb.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
    check(out_rdy, 1'b0);
    hb.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
    check(out_rdy, 1'b0);
    hb.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
    check(out_rdy, 1'b1);
    check(b_data, W1);
    check(b_oe, 1'b1);
    // Retransmit: mark, read on, run dry, restart, leave
    @(posedge core_clk);
    misc.retx_mode_sel <= 1'b1;
    hb.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
    reg_rd(REG_STATUS, v);
    check(v[4], 1'b1);
    hb.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
    check(b_data, W2);
    hb.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
    check(out_rdy, 1'b0);
    hb.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
    check(b_data, W2);
    @(posedge core_clk);
    misc.retx_restart <= 1'b1;
    hb.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
    check(b_data, W1);
    check(out_rdy, 1'b1);
    @(posedge core_clk);
    misc.retx_restart  <= 1'b0;
    misc.retx_mode_sel <= 1'b0;
    hb.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
    reg_rd(REG_STATUS, v);
    check(v[4], 1'b0);
    // Mailboxes both ways
    ha.op(1'b0, 1'b1, 1'b1, 1'b1, MA);
    check(mb_flag_n, 1'b0);
    hb.op(1'b0, 1'b1, 1'b1, 1'b1, 36'h0);
    check(b_data, MA);
    check(mb_flag_n, 1'b1);
    hb.op(1'b0, 1'b0, 1'b1, 1'b1, MB);
    check(ma_flag_n, 1'b0);
    check(b_oe, 1'b0);
    ha.op(1'b0, 1'b0, 1'b0, 1'b1, 36'h0);
    check(ma_flag_n, 1'b0);
    check(a_data, MB);
    check(a_oe, 1'b1);
    ha.op(1'b0, 1'b0, 1'b1, 1'b1, 36'h0);
    check(ma_flag_n, 1'b1);
    hb.op(1'b0, 1'b0, 1'b1, 1'b1, MB);
    // Pin clear over four edges of each port, parallel method
    @(posedge core_clk);
    misc.clear_n <= 1'b0;
    misc.sel_hi  <= 1'b0;
    misc.sel_lo  <= 1'b0;
    repeat (4)
    begin
      ha.op(1'b1, 1'b1, 1'b0, 1'b0, 36'h0);
      hb.op(1'b1, 1'b1, 1'b0, 1'b0, 36'h0);
    end
    check(ma_flag_n, 1'b1);
    check(in_rdy, 1'b0);
    check(out_rdy, 1'b0);
    @(posedge core_clk);
    misc.clear_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    repeat (2) ha.op(1'b1, 1'b1, 1'b0, 1'b0, 36'h0);
    check(in_rdy, 1'b1);
    ha.op(1'b0, 1'b1, 1'b1, 1'b0, 36'hABCDEF123);
    ha.op(1'b0, 1'b1, 1'b1, 1'b0, 36'h123455456);
    ha.op(1'b0, 1'b1, 1'b1, 1'b0, W3);
    reg_rd(REG_OFFSETS, v);
    check(v, 32'h01230456);
    repeat (3) hb.op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
    check(out_rdy, 1'b1);
    check(b_data, W3);
    // Serial method through the soft clear
    soft_clear(1'b1, 1'b1);
    reg_rd(REG_STATUS, v);
    check(v[6:5], 2'b11);
    for (int i = 21; i >= 0; i--)
    begin
      @(posedge core_clk);
      misc.sel_hi <= 1'b0;
      misc.sel_lo <= SER[i];
      ha.op(1'b1, 1'b1, 1'b0, 1'b0, 36'h0);
    end
    check(in_rdy, 1'b0);
    @(posedge core_clk);
    misc.sel_hi <= 1'b1;
    ha.op(1'b1, 1'b1, 1'b0, 1'b0, 36'h0);
    check(in_rdy, 1'b1);
    reg_rd(REG_OFFSETS, v);
    check(v, 32'h07FC0001);
    // Preset 64, unmapped write ignored
    soft_clear(1'b1, 1'b0);
    reg_wr(4'hC, 32'hFFFFFFFF);
    reg_rd(4'hC, v);
    check(v, 32'h0);
    reg_rd(REG_OFFSETS, v);
    check(v, 32'h00400040);
    reg_rd(REG_STATUS, v);
    check(v[6:5], 2'b10);
    finish_test();
  end
endmodule : sync_fifo_ctl_tb
